// [src/byte_fifo.v]
// Byte FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active high reset.
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock and reset.
   input wire clk_in,
   input wire reset_in,
   // Fill side.
   input wire [WIDTH-1:0] wr_data_in,
   input wire wr_valid_in,
   output wire wr_ready_out,
   // Drain side.
   output wire [WIDTH-1:0] rd_data_out,
   output wire rd_valid_out,
   input wire rd_ready_in
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   assign wr_ready_out = (count != DEPTH[AW:0]);
   assign rd_valid_out = (count != {(AW+1){1'b0}});
   assign rd_data_out = mem[rd_ptr];
   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in;
   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= wr_data_in;
      end
      if (reset_in) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // byte_fifo

// [src/imu_i2c_regs.vh]
// Constants for the two-die I2C register access block.
// Assumes inclusion by bare name from the design files.
`ifndef IMU_I2C_REGS_VH
`define IMU_I2C_REGS_VH
`define ACCEL_ADDR_BASE 7'h18
`define GYRO_ADDR_BASE 7'h68
`define PTR_RESET 8'h00
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define STRAP_WAIT 2'h2
`endif

// [src/imu_i2c_target.v]
// I2C target register access for one die of a two-die inertial sensor.
// Assumes SCL and SDA are pins sampled by clk_in (125 MHz), straps static.
`include "imu_i2c_regs.vh"
module imu_i2c_target (
   // Clock and reset.
   input wire clk_in,
   input wire reset_in,
   // I2C pins; sda_oe_n_out low means the pin is pulled low.
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n_out,
   // Straps and die choice (1 selects the gyroscope die).
   input wire gyro_die_in,
   input wire protocol_select_strap_in,
   input wire accel_serial_out_addr_strap_in,
   input wire gyro_serial_out_addr_strap_in,
   // Written bytes toward the register file.
   output reg [7:0] wr_addr_out,
   output reg [7:0] wr_data_out,
   output reg wr_strobe_out,
   // Read data from the register file, pushed by logic on clk_in.
   input wire [7:0] rd_data_in,
   input wire rd_valid_in,
   output reg rd_ready_out,
   output reg [7:0] rd_addr_out,
   output reg i2c_enable_out,
   output reg busy_out
);
   // ==========================================================
   // Pin synchronisation and bus condition detection
   wire [4:0] synced;
   reg scl_d;
   reg sda_d;
   wire scl_s;
   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   // The straps share the pin synchroniser. Its reset value is all ones,
   // the idle level of both bus lines, so no false edge follows reset.
   sync2 #(.WIDTH(5), .INIT(5'h1f)) u_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .async_in({scl_in, sda_in, protocol_select_strap_in,
                 accel_serial_out_addr_strap_in,
                 gyro_serial_out_addr_strap_in}),
      .sync_out(synced)
   );
   assign scl_s = synced[4];
   assign sda_s = synced[3];
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_det = scl_s && scl_d && sda_d && !sda_s;
   assign stop_det = scl_s && scl_d && !sda_d && sda_s;

   // ==========================================================
   // Strap capture after reset release
   // Straps are read once; moving them later needs a reset.
   reg [6:0] own_addr;
   reg strap_done;
   reg [1:0] strap_wait;
   always @(posedge clk_in) begin
      if (reset_in) begin
         own_addr <= 7'h00;
         i2c_enable_out <= 1'b0;
         strap_done <= 1'b0;
         strap_wait <= 2'h0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         // The synchroniser shows its reset value for two more edges;
         // capturing earlier would read every strap as high.
         if (!strap_done && strap_wait != `STRAP_WAIT) begin
            strap_wait <= strap_wait + 2'h1;
         end else if (!strap_done) begin
            strap_done <= 1'b1;
            i2c_enable_out <= synced[2] || !gyro_die_in;
            if (gyro_die_in) begin
               own_addr <= `GYRO_ADDR_BASE | {6'h00, synced[0]};
            end else begin
               own_addr <= `ACCEL_ADDR_BASE | {6'h00, synced[1]};
            end
         end
      end
   end

   // ==========================================================
   // Read data buffer between register file and the shifter
   wire fifo_wr_ready;
   wire [7:0] fifo_data;
   wire fifo_valid;
   reg fifo_pop;
   reg fifo_flush;
   // A byte enters only on a completed handshake, so the register
   // file's pointer and the buffer contents never drift apart.
   byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
      .clk_in(clk_in),
      .reset_in(reset_in || fifo_flush),
      .wr_data_in(rd_data_in),
      .wr_valid_in(rd_valid_in && rd_ready_out),
      .wr_ready_out(fifo_wr_ready),
      .rd_data_out(fifo_data),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(fifo_pop)
   );

   // ==========================================================
   // Protocol state machine
   // Bits are taken on synchronised SCL rises and driven after falls,
   // about three clocks late; both edges lag alike, so setup holds.
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_AACK = 7'h04;
   localparam [6:0] S_RXB = 7'h08;
   localparam [6:0] S_RACK = 7'h10;
   localparam [6:0] S_TXB = 7'h20;
   localparam [6:0] S_MACK = 7'h40;
   reg [6:0] state;
   reg [7:0] shreg;
   reg [3:0] bitcnt;
   reg rw;
   reg got_ptr;
   reg ack_hi;
   reg load_pend;
   reg [7:0] start_ptr;
   reg [7:0] ptr;
   always @(posedge clk_in) begin
      if (reset_in) begin
         state <= S_IDLE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         rw <= 1'b0;
         got_ptr <= 1'b0;
         ack_hi <= 1'b0;
         load_pend <= 1'b0;
         start_ptr <= `PTR_RESET;
         ptr <= `PTR_RESET;
         sda_out <= 1'b0;
         sda_oe_n_out <= 1'b1;
         wr_addr_out <= 8'h00;
         wr_data_out <= 8'h00;
         wr_strobe_out <= 1'b0;
         rd_ready_out <= 1'b0;
         rd_addr_out <= 8'h00;
         busy_out <= 1'b0;
         fifo_pop <= 1'b0;
         fifo_flush <= 1'b0;
      end else begin
         wr_strobe_out <= 1'b0;
         fifo_pop <= 1'b0;
         fifo_flush <= 1'b0;
         // Ready drops for one cycle after each take: the take that
         // fills the last free entry can then never be followed by one
         // the full buffer would have to refuse.
         rd_ready_out <= busy_out && rw && fifo_wr_ready &&
                         !(rd_valid_in && rd_ready_out);
         if (rd_valid_in && rd_ready_out) begin
            rd_addr_out <= rd_addr_out + 8'h01;
         end
         if (!i2c_enable_out) begin
            state <= S_IDLE;
            sda_oe_n_out <= 1'b1;
         end else if (start_det) begin
            // Repeated START keeps the pointer of the write phase.
            state <= S_ADDR;
            bitcnt <= 4'h0;
            got_ptr <= 1'b0;
            sda_oe_n_out <= 1'b1;
            busy_out <= 1'b0;
            load_pend <= 1'b0;
            fifo_flush <= 1'b1;
         end else if (stop_det) begin
            // A STOP is taken in every state, even with no clock since START.
            state <= S_IDLE;
            sda_oe_n_out <= 1'b1;
            busy_out <= 1'b0;
         end else begin
            case (state)
               S_IDLE: begin
                  sda_oe_n_out <= 1'b1;
               end
               S_ADDR, S_RXB: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     bitcnt <= 4'h0;
                     if (state == S_ADDR) begin
                        if (shreg[7:1] == own_addr) begin
                           rw <= shreg[0];
                           sda_oe_n_out <= 1'b0;
                           state <= S_AACK;
                           if (shreg[0]) begin
                              // Prefetch during the acknowledge so the
                              // first byte waits at its closing fall.
                              rd_addr_out <= start_ptr;
                              busy_out <= 1'b1;
                              ack_hi <= 1'b0;
                           end
                        end else begin
                           state <= S_IDLE;
                        end
                     end else begin
                        sda_oe_n_out <= 1'b0;
                        state <= S_RACK;
                        // The first byte after the address is the pointer;
                        // later bytes go to consecutive registers.
                        if (!got_ptr) begin
                           got_ptr <= 1'b1;
                           start_ptr <= shreg;
                           ptr <= shreg;
                        end else begin
                           wr_addr_out <= ptr;
                           wr_data_out <= shreg;
                           wr_strobe_out <= 1'b1;
                           ptr <= ptr + 8'h01;
                        end
                     end
                  end
               end
               S_AACK: begin
                  if (scl_fall) begin
                     if (rw) begin
                        load_pend <= 1'b1;
                        state <= S_MACK;
                     end else begin
                        sda_oe_n_out <= 1'b1;
                        state <= S_RXB;
                     end
                  end
               end
               S_RACK: begin
                  // Hold the acknowledge through its clock, then let go.
                  if (scl_fall) begin
                     sda_oe_n_out <= 1'b1;
                     state <= S_RXB;
                  end
               end
               S_TXB: begin
                  // Bit 7 went out at the load; each fall shifts the next,
                  // and the fall after bit 0 frees the line for the answer.
                  if (scl_fall) begin
                     if (bitcnt == 4'h7) begin
                        sda_oe_n_out <= 1'b1;
                        bitcnt <= 4'h0;
                        state <= S_MACK;
                     end else begin
                        sda_oe_n_out <= shreg[6];
                        shreg <= {shreg[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               S_MACK: begin
                  // The controller clock is not stretched: a byte that is
                  // not buffered at the fall goes out as soon as it lands,
                  // so the register file must keep up.
                  if (scl_rise) begin
                     ack_hi <= sda_s;
                  end else if (ack_hi) begin
                     sda_oe_n_out <= 1'b1;
                     busy_out <= 1'b0;
                     load_pend <= 1'b0;
                     state <= S_IDLE;
                  end else if ((scl_fall || load_pend) && fifo_valid) begin
                     load_pend <= 1'b0;
                     fifo_pop <= 1'b1;
                     shreg <= fifo_data;
                     sda_oe_n_out <= fifo_data[7];
                     state <= S_TXB;
                  end else if (scl_fall) begin
                     load_pend <= 1'b1;
                  end
               end
               default: begin
                  state <= S_IDLE;
                  sda_oe_n_out <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // imu_i2c_target

// [src/sync2.v]
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes the levels are quasi-static relative to clk_in.
module sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   input wire clk_in,
   input wire reset_in,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;
   always @(posedge clk_in) begin
      if (reset_in) begin
         meta <= INIT;
         sync_out <= INIT;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule // sync2

// [tb/i2c_ctrl_model.sv]
// Bus controller model facing the I2C target block.
// Assumes the bench resolves SDA with a pull-up; SCL idles high.
module i2c_ctrl_model (
   // Pacing clock.
   input wire logic clk_in,
   // Bus lines; sda_drv_out high means released.
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_drv_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // ===================================================
   // Bus steps: four quarters of 40 ns make one 160 ns bit.
   task automatic q;
      repeat (5) @(posedge clk_in);
      #1;
   endtask
   task automatic clk_bit(input logic b, output logic r);
      sda_drv_out = b;
      q;
      scl_out = 1'b1;
      q;
      r = sda_in;
      q;
      scl_out = 1'b0;
      q;
   endtask
   task automatic start;
      sda_drv_out = 1'b1;
      q;
      scl_out = 1'b1;
      q;
      sda_drv_out = 1'b0;
      q;
      scl_out = 1'b0;
      q;
   endtask
   // Always clocked before use, so no bare start and stop pair occurs.
   task automatic stop;
      sda_drv_out = 1'b0;
      q;
      scl_out = 1'b1;
      q;
      sda_drv_out = 1'b1;
      q;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], r);
      clk_bit(1'b1, nak);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, d[i]);
      clk_bit(last, r);
   endtask
endmodule // i2c_ctrl_model

// [tb/imu_i2c_target_assertions.sv]
// Port checker for the I2C target block.
// Assumes it is bound onto every imu_i2c_target instance.
module imu_i2c_target_assertions (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_in,
   // Watched ports.
   input wire logic sda_out,
   input wire logic sda_oe_n_out,
   input wire logic gyro_die_in,
   input wire logic protocol_select_strap_in,
   input wire logic wr_strobe_out,
   input wire logic rd_valid_in,
   input wire logic rd_ready_out,
   input wire logic [7:0] rd_addr_out,
   input wire logic i2c_enable_out,
   input wire logic busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ===================================================
   // Properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_take;
      rd_valid_in && rd_ready_out;
   endsequence
   sequence s_take_read;
      s_take ##1 busy_out;
   endsequence
   a_spi_off: assert property (
      (gyro_die_in && !protocol_select_strap_in)[*8] |-> !i2c_enable_out)
      else $error("i2c left on");
   a_i2c_on: assert property (
      (!gyro_die_in || protocol_select_strap_in)[*8] |-> i2c_enable_out)
      else $error("i2c not on");
   a_spi_quiet: assert property (!i2c_enable_out |-> sda_oe_n_out)
      else $error("sda driven while off");
   a_drive_zero: assert property (!sda_oe_n_out |-> !sda_out)
      else $error("sda driven high");
   // A read address acknowledge running on into a first byte of zeros is the longest drive, so the bound covers it.
   a_drive_bound: assert property (
      $fell(sda_oe_n_out) |-> ##[1:200] sda_oe_n_out)
      else $error("sda never released");
   a_strobe_pulse: assert property (wr_strobe_out |=> !wr_strobe_out)
      else $error("strobe too long");
   a_strobe_write: assert property (wr_strobe_out |-> !busy_out)
      else $error("strobe during read");
   a_ptr_step: assert property (
      s_take_read |-> rd_addr_out == 8'($past(rd_addr_out) + 8'h01))
      else $error("pointer did not step");
   a_ready_gap: assert property (s_take |=> !rd_ready_out)
      else $error("ready held after take");
endmodule // imu_i2c_target_assertions

bind imu_i2c_target imu_i2c_target_assertions u_chk (
   .clk_in(clk_in), .reset_in(reset_in), .sda_out(sda_out),
   .sda_oe_n_out(sda_oe_n_out), .gyro_die_in(gyro_die_in),
   .protocol_select_strap_in(protocol_select_strap_in),
   .wr_strobe_out(wr_strobe_out), .rd_valid_in(rd_valid_in),
   .rd_ready_out(rd_ready_out), .rd_addr_out(rd_addr_out),
   .i2c_enable_out(i2c_enable_out), .busy_out(busy_out));

// [tb/imu_i2c_target_tb.sv]
// Self-checking bench for the I2C target block.
// Assumes the controller model and the checker are compiled with it.
`include "imu_i2c_regs.vh"
module imu_i2c_target_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic die, ps, acc_s, gyr_s, rd_valid, scl, sda_drv, sda, sda_o;
   logic sda_oe_n, wr_strobe, rd_ready, i2c_en, busy;
   logic [7:0] wr_addr, wr_data, rd_addr;
   logic [7:0] mem [256];
   int error_cnt = 0;
   int checks = 0;
   always #4 clk_in = ~clk_in;
   assign sda = sda_drv & (sda_oe_n | sda_o);
   // The register file stalls at random to exercise the prefetch buffer.
   always @(posedge clk_in) begin
      rd_valid <= #1 ($urandom_range(3) != 0);
      if (wr_strobe)
         mem[wr_addr] <= wr_data;
   end
   imu_i2c_target dut (
      .clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .gyro_die_in(die),
      .protocol_select_strap_in(ps),
      .accel_serial_out_addr_strap_in(acc_s),
      .gyro_serial_out_addr_strap_in(gyr_s), .wr_addr_out(wr_addr),
      .wr_data_out(wr_data), .wr_strobe_out(wr_strobe),
      .rd_data_in(mem[rd_addr]), .rd_valid_in(rd_valid),
      .rd_ready_out(rd_ready), .rd_addr_out(rd_addr),
      .i2c_enable_out(i2c_en), .busy_out(busy));
   i2c_ctrl_model m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
      .sda_drv_out(sda_drv));
   // ===================================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Target address from the die choice and its address strap.
   function automatic logic [6:0] addr_of(input logic gyro, input logic s);
      return (gyro ? `GYRO_ADDR_BASE : `ACCEL_ADDR_BASE) | {6'h00, s};
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] p,
                     input int n, input bit wr);
      logic nak;
      logic [7:0] d;
      if (wr) begin
         m.start;
         m.wbyte({a, 1'b0}, nak);
         m.wbyte(p, nak);
      end
      m.start;
      m.wbyte({a, 1'b1}, nak);
      chk({7'h00, nak}, 8'h00);
      for (int i = 0; i < n; i++) begin
         m.rbyte(i == n - 1, d);
         chk(d, mem[8'(p + i)]);
      end
      m.stop;
      repeat (4) @(posedge clk_in);
      #1;
      chk({7'h00, sda_oe_n}, 8'h01);
   endtask
   // ===================================================
   // Main sequence
   initial begin
      logic nak;
      logic [6:0] a;
      logic [7:0] p, d;
      die = 1'b0;
      ps = 1'b1;
      acc_s = 1'b0;
      gyr_s = 1'b0;
      rd_valid = 1'b0;
      void'($urandom(32'h60b5));
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5a;
      for (int c = 0; c < 5; c++) begin
         reset_in = 1'b1;
         die = (c >= 2);
         ps = (c < 2) ? 1'($urandom) : (c != 4);
         acc_s = c[0] ^ die;
         gyr_s = c[0] ^ !die;
         a = addr_of(die, die ? gyr_s : acc_s);
         repeat (5) @(posedge clk_in);
         #1 reset_in = 1'b0;
         repeat (10) @(posedge clk_in);
         #1;
         m.start;
         m.wbyte({a, 1'b0}, nak);
         m.stop;
         chk({7'h00, nak}, {7'h00, c == 4});
         if (c == 4)
            continue;
         rd(a, 8'h00, 2, 0);
         p = 8'($urandom);
         d = mem[p];
         m.start;
         m.wbyte({a ^ 7'h40, 1'b0}, nak);
         chk({7'h00, nak}, 8'h01);
         m.wbyte(p, nak);
         m.wbyte(~d, nak);
         m.stop;
         chk(mem[p], d);
         d = 8'($urandom);
         m.start;
         m.wbyte({a, 1'b0}, nak);
         m.wbyte(p, nak);
         chk({7'h00, nak}, 8'h00);
         m.wbyte(d, nak);
         chk({7'h00, nak}, 8'h00);
         m.stop;
         chk(mem[p], d);
         rd(a, p, 1 + $urandom_range(33), 1);
         rd(a, p, 2, 0);
      end
      wrap_up;
   end
   initial begin
      #800000;
      error_cnt++;
      wrap_up;
   end
endmodule // imu_i2c_target_tb
